/* hdl/sfers_params.svh */
`ifndef SFERS_PARAMS_SVH
`define SFERS_PARAMS_SVH
`define SFERS_CLK_PERIOD_NS   10
`define SFERS_RST_DELAY_MS    200
`define SFERS_RST_DELAY_CYC   ((`SFERS_RST_DELAY_MS * 1000000) / `SFERS_CLK_PERIOD_NS)
`define SFERS_DELAY_W         25
`define SFERS_OPC_W           8
`endif

/* hdl/sfers_pkg.sv */
package sfers_pkg;
   typedef enum logic [1:0] {
      SFERS_ST_LOCKED,
      SFERS_ST_IDLE,
      SFERS_ST_ACTIVE
   } sfers_link_t;

   typedef enum logic [1:0] {
      SFERS_RS_POWEROFF,
      SFERS_RS_HOLD,
      SFERS_RS_RUN
   } sfers_rst_t;

   typedef struct packed {
      logic csN;
      logic sck;
      logic si;
      logic wpN;
   } sfers_pins_t;

   typedef struct packed {
      logic so;
      logic soOe;
   } sfers_sout_t;
endpackage : sfers_pkg

/* hdl/sfers_front_end.sv */
// Overview of operation
// - with chip select high the device is deselected and its serial output is not driven.
// - deselected, the device drops to standby unless a nonvolatile write is still running.
// - chip select low enables the device in its active state, ready for serial input.
// - after power-up all serial activity is ignored until the first falling edge of chip select.
// - the serial output is driven during reads and each bit changes on the serial clock falling edge.
// - serial input bits are sampled on each rising edge of the serial clock.
// - the open-drain reset output asserts, at the variant's polarity, whenever supply is below the trip threshold but above about 1V.
// - reset stays asserted for 200ms after supply rises above the threshold, at power-up and after brownout.
// - reset is asserted from about 1V of supply and held during brownout until supply falls below about 1V.
// - the write-protect pin with the protect lock enable bit locks protect and timer settings.
// - the serial clock is static, so a paused transfer resumes where it stopped.
`timescale 1ns/1ps
`default_nettype none
`include "sfers_params.svh"

module sfers_front_end #(
   parameter int                RST_DELAY_CYC = `SFERS_RST_DELAY_CYC,
   parameter bit                RST_ACT_HIGH  = 1'b0,
   parameter int                OPC_W         = `SFERS_OPC_W
) (
   input  wire logic            ref_clk,
   input  wire logic            nrst,
   input  wire logic            csN,
   input  wire logic            sck,
   input  wire logic            si,
   input  wire logic            wpN,
   input  wire logic            supplyAboveTrip,
   input  wire logic            supplyAboveMin,
   input  wire logic            protectLockEnableBit,
   input  wire logic            nvWriteBusy,
   input  wire logic            readActive,
   input  wire logic            txBit,
   output logic                 so,
   output logic                 soOe,
   output logic                 rstOut,
   output logic                 rstOe,
   output logic                 standby,
   output logic                 active,
   output logic                 rxValid,
   output logic [OPC_W-1:0]     rxByte,
   output logic                 txTake,
   output logic                 settingsLocked
);

   typedef struct packed {
      sfers_pkg::sfers_link_t   link;
      sfers_pkg::sfers_rst_t    rsm;
      logic [`SFERS_DELAY_W-1:0] delay;
      logic                     sckQ;
      logic                     csQ;
      logic [2:0]               bitCnt;
      logic [OPC_W-1:0]         shift;
      logic                     rxValid;
      logic [OPC_W-1:0]         rxByte;
      logic                     txTake;
      sfers_pkg::sfers_sout_t   sout;
      logic                     rstAsserted;
      logic                     rstPull;
      logic                     standby;
      logic                     active;
      logic                     locked;
   } sfers_state_t;

   sfers_state_t st;
   sfers_state_t next_st;
   sfers_pkg::sfers_pins_t pins;

   localparam logic [`SFERS_DELAY_W-1:0] DELAY_LAST = `SFERS_DELAY_W'(RST_DELAY_CYC - 1);

   logic sckRise;
   logic sckFall;
   logic csFall;

   assign pins    = '{csN: csN, sck: sck, si: si, wpN: wpN};
   // pins are synchronous by contract, so edges come from one registered copy
   assign sckRise = pins.sck & ~st.sckQ;
   assign sckFall = ~pins.sck & st.sckQ;
   assign csFall  = ~pins.csN & st.csQ;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st         = st;
      next_st.sckQ    = pins.sck;
      next_st.csQ     = pins.csN;
      next_st.rxValid = 1'b0;
      next_st.txTake  = 1'b0;
      next_st.locked  = protectLockEnableBit & ~pins.wpN;

      // serial link
      case (st.link)
         sfers_pkg::SFERS_ST_LOCKED: begin
            if (csFall) begin
               next_st.link   = sfers_pkg::SFERS_ST_ACTIVE;
               next_st.bitCnt = 3'h0;
            end
         end
         sfers_pkg::SFERS_ST_IDLE: begin
            if (!pins.csN) begin
               next_st.link   = sfers_pkg::SFERS_ST_ACTIVE;
               next_st.bitCnt = 3'h0;
            end
         end
         sfers_pkg::SFERS_ST_ACTIVE: begin
            if (pins.csN) begin
               next_st.link = sfers_pkg::SFERS_ST_IDLE;
            end else begin
               // no timeout on the clock: a pause simply holds the shift state
               if (sckRise) begin
                  next_st.shift  = {st.shift[OPC_W-2:0], pins.si};
                  next_st.bitCnt = st.bitCnt + 3'h1;
                  if (st.bitCnt == 3'h7) begin
                     next_st.rxValid = 1'b1;
                     next_st.rxByte  = {st.shift[OPC_W-2:0], pins.si};
                  end
               end
               if (sckFall && readActive) begin
                  next_st.sout.so = txBit;
                  next_st.txTake  = 1'b1;
               end
            end
         end
         default: next_st.link = sfers_pkg::SFERS_ST_LOCKED;
      endcase

      next_st.sout.soOe = (next_st.link == sfers_pkg::SFERS_ST_ACTIVE) && readActive;
      next_st.active    = (next_st.link == sfers_pkg::SFERS_ST_ACTIVE);
      next_st.standby   = !next_st.active && !nvWriteBusy;

      // reset supervisor
      case (st.rsm)
         sfers_pkg::SFERS_RS_POWEROFF: begin
            if (supplyAboveMin) begin
               next_st.rsm   = sfers_pkg::SFERS_RS_HOLD;
               next_st.delay = '0;
            end
         end
         sfers_pkg::SFERS_RS_HOLD: begin
            if (!supplyAboveMin) begin
               next_st.rsm = sfers_pkg::SFERS_RS_POWEROFF;
            end else if (!supplyAboveTrip) begin
               next_st.delay = '0;
            end else if (st.delay == DELAY_LAST) begin
               next_st.rsm = sfers_pkg::SFERS_RS_RUN;
            end else begin
               next_st.delay = st.delay + 1'b1;
            end
         end
         sfers_pkg::SFERS_RS_RUN: begin
            if (!supplyAboveTrip) begin
               next_st.rsm   = sfers_pkg::SFERS_RS_HOLD;
               next_st.delay = '0;
            end
         end
         default: next_st.rsm = sfers_pkg::SFERS_RS_POWEROFF;
      endcase
      // below ~1V the pin floats; above it, held until the run state
      next_st.rstAsserted = (next_st.rsm == sfers_pkg::SFERS_RS_HOLD);
      // pull-down enable kept in a flop so the pin never sees a decode glitch
      next_st.rstPull     = RST_ACT_HIGH ? (next_st.rsm == sfers_pkg::SFERS_RS_RUN)
                                         : (next_st.rsm == sfers_pkg::SFERS_RS_HOLD);
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st      <= '0;
         st.link <= sfers_pkg::SFERS_ST_LOCKED;
         st.rsm  <= sfers_pkg::SFERS_RS_POWEROFF;
         st.sckQ <= 1'b0;
         // a select already low at reset must not count as the first falling edge
         st.csQ  <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // open drain: active-low variant pulls low; active-high variant releases to pull-up
   assign so             = st.sout.so;
   assign soOe           = st.sout.soOe;
   assign rstOut         = 1'b0;
   assign rstOe          = st.rstPull;
   assign standby        = st.standby;
   assign active         = st.active;
   assign rxValid        = st.rxValid;
   assign rxByte         = st.rxByte;
   assign txTake         = st.txTake;
   assign settingsLocked = st.locked;

   ////////////////////////////////////////////////////////////////////////////
   // supply states as seen by the comparators, then the supervisor hold and run states
   sequence s_dip;
      !supplyAboveTrip && supplyAboveMin;
   endsequence

   sequence s_rise;
      supplyAboveTrip && supplyAboveMin;
   endsequence

   sequence s_held;
      st.rsm == sfers_pkg::SFERS_RS_HOLD;
   endsequence

   sequence s_run;
      st.rsm == sfers_pkg::SFERS_RS_RUN;
   endsequence

   // a byte ends on the rising edge that carries its last bit
   sequence s_last_bit;
      active && !csN && sckRise && (st.bitCnt == 3'h7);
   endsequence

   AST_DESELECT_HIZ: assert property (@(posedge ref_clk) disable iff (!nrst)
      csN |=> !soOe)
      else $error("serial output driven while deselected");

   AST_STANDBY: assert property (@(posedge ref_clk) disable iff (!nrst)
      standby |-> !active && !$past(nvWriteBusy))
      else $error("standby during write or active");

   AST_ACTIVE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st.link == sfers_pkg::SFERS_ST_IDLE && !csN) |=> active)
      else $error("select did not activate");

   AST_FIRST_EDGE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st.link == sfers_pkg::SFERS_ST_LOCKED && !csFall) |=> !active && !rxValid)
      else $error("activity before first select edge");

   AST_SO_FALL: assert property (@(posedge ref_clk) disable iff (!nrst)
      $changed(so) |-> $past(sckFall))
      else $error("output changed off falling edge");

   AST_SAMPLE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (active && !csN && sckRise) |=> st.shift[0] == $past(si))
      else $error("input bit not sampled");

   AST_DIP_ASSERTS: assert property (@(posedge ref_clk) disable iff (!nrst)
      (s_dip ##1 s_dip) |=> st.rstAsserted)
      else $error("reset not asserted on dip");

   AST_DELAY_RESTART: assert property (@(posedge ref_clk) disable iff (!nrst)
      (s_held and s_dip) |=> st.delay == '0)
      else $error("delay not restarted");

   AST_HOLD_TIME: assert property (@(posedge ref_clk) disable iff (!nrst)
      ((s_held and s_rise) ##1 s_run) |-> $past(st.delay) == DELAY_LAST)
      else $error("reset released early");

   AST_LOCK: assert property (@(posedge ref_clk) disable iff (!nrst)
      (protectLockEnableBit && !wpN) |=> settingsLocked)
      else $error("settings not locked");

   ////////////////////////////////////////////////////////////////////////////
   // pulses, select and pin levels
   AST_RX_PULSE: assert property (@(posedge ref_clk) disable iff (!nrst)
      rxValid |=> !rxValid)
      else $error("byte strobe longer than one cycle");

   AST_TX_PULSE: assert property (@(posedge ref_clk) disable iff (!nrst)
      txTake |=> !txTake)
      else $error("bit take strobe longer than one cycle");

   AST_ACTIVE_DROP: assert property (@(posedge ref_clk) disable iff (!nrst)
      (active && csN) |=> !active)
      else $error("still active after deselect");

   AST_IDLE_HIZ: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st.link != sfers_pkg::SFERS_ST_ACTIVE) |-> !soOe)
      else $error("serial output driven outside a transfer");

   AST_LOCKED_QUIET: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st.link == sfers_pkg::SFERS_ST_LOCKED) |-> !active && !soOe)
      else $error("link awake before first select edge");

   AST_STANDBY_SET: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!active && csN && !nvWriteBusy) |=> standby)
      else $error("standby not entered");

   AST_BUSY_AWAKE: assert property (@(posedge ref_clk) disable iff (!nrst)
      nvWriteBusy |=> !standby)
      else $error("standby during nonvolatile write");

   AST_OE_READ: assert property (@(posedge ref_clk) disable iff (!nrst)
      (active && !csN && readActive) |=> soOe)
      else $error("serial output not driven in read");

   AST_BYTE_DONE: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_last_bit |=> rxValid)
      else $error("byte not delivered after eighth bit");

   AST_RST_LEVEL: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_held |-> (rstOe != RST_ACT_HIGH))
      else $error("reset pin not at asserted level");

   ////////////////////////////////////////////////////////////////////////////
   // supervisor timing and settings lock release
   AST_POWEROFF_FLOAT: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st.rsm == sfers_pkg::SFERS_RS_POWEROFF) |-> !rstOe && !st.rstAsserted)
      else $error("reset pin driven below minimum supply");

   AST_POWERUP: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st.rsm == sfers_pkg::SFERS_RS_POWEROFF && supplyAboveMin) |=> st.rstAsserted)
      else $error("reset not asserted at power-up");

   AST_RUN_STAYS: assert property (@(posedge ref_clk) disable iff (!nrst)
      (s_run and s_rise) |=> s_run)
      else $error("reset asserted with good supply");

   AST_DELAY_COUNT: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st.rsm == sfers_pkg::SFERS_RS_HOLD && supplyAboveTrip && supplyAboveMin && st.delay != DELAY_LAST)
      |=> st.delay == $past(st.delay) + 1'b1)
      else $error("release delay not counting");

   AST_LOCK_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
      !(protectLockEnableBit && !wpN) |=> !settingsLocked)
      else $error("settings locked without lock condition");
endmodule : sfers_front_end
`default_nettype wire

/* testbench/sfers_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfers_host_model (
   input  wire logic ref_clk,
   input  wire logic so,
   output logic      csN,
   output logic      sck,
   output logic      si
);
   logic [7:0] seen;
   initial begin
      csN = 1'b0;
      sck = 1'b0;
      si = 1'b0;
   end
   // 3 cycles per level keeps above the 1-cycle minimum the front end needs
   task automatic half(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : half
   task automatic xfer(input logic [7:0] d, input int nb, input int pauseAt);
      for (int i = 7; i > 7 - nb; i--) begin
         si <= d[i];
         half(3);
         sck <= 1'b1;
         half(3);
         sck <= 1'b0;
         half(3);
         seen[i] = so;
         if (i == pauseAt) half(40);
      end
   endtask : xfer
   // trip programming: clock and data held high stand in for the programming level
   task automatic set_trip;
      @(posedge ref_clk);
      sck <= 1'b1;
      si  <= 1'b1;
      half(4);
      csN <= 1'b0;
      half(4);
      csN <= 1'b1;
      half(4);
      sck <= 1'b0;
      si  <= 1'b0;
      half(4);
   endtask : set_trip
   task automatic sel(input logic v);
      @(posedge ref_clk);
      csN <= v;
      // an idle data line must not keep showing the last bit
      si <= ~si;
      half(4);
   endtask : sel
endmodule : sfers_host_model
`default_nettype wire

/* testbench/tb_spi_front_end_reset_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_spi_front_end_reset_supervisor;
   localparam int DLY = 20;
   logic ref_clk = 1'b0, nrst = 1'b0, wpN = 1'b1, readActive = 1'b0, nvWriteBusy = 1'b0;
   logic supplyAboveTrip = 1'b0, supplyAboveMin = 1'b0, protectLockEnableBit = 1'b0;
   logic [7:0] txReg = 8'h00, d, e, expQ[$];
   wire logic csN, sck, si, so, soOe, rstOut, rstOe, standby, active, rxValid, txTake, settingsLocked;
   wire logic [7:0] rxByte;
   int fail_count = 0, total_checks = 0, n;
   initial forever #5 ref_clk = ~ref_clk;
   sfers_front_end #(.RST_DELAY_CYC(DLY)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .csN(csN), .sck(sck),
      .si(si), .wpN(wpN), .supplyAboveTrip(supplyAboveTrip), .supplyAboveMin(supplyAboveMin),
      .protectLockEnableBit(protectLockEnableBit), .nvWriteBusy(nvWriteBusy), .readActive(readActive),
      .txBit(txReg[7]), .so(so), .soOe(soOe), .rstOut(rstOut), .rstOe(rstOe), .standby(standby),
      .active(active), .rxValid(rxValid), .rxByte(rxByte), .txTake(txTake), .settingsLocked(settingsLocked));
   sfers_host_model host_u (.ref_clk(ref_clk), .so(so), .csN(csN), .sck(sck), .si(si));
   always @(posedge ref_clk) if (txTake === 1'b1) txReg <= {txReg[6:0], 1'b0};
   // sampled on the falling edge so the pulse has settled
   always @(negedge ref_clk) if (rxValid === 1'b1) begin
      if (expQ.size() == 0) `CHK("unexpected rxValid", 1'b0, 1'b1)
      else begin
         e = expQ.pop_front();
         `CHK("rxByte", e, rxByte)
      end
   end
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
   endtask : tick
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   initial begin
      void'($urandom(34612));
      tick(10);
      nrst <= 1'b1;
      tick(2);
      // select held low since reset: no falling edge seen, so all is ignored
      readActive <= 1'b1;
      host_u.xfer(8'ha5, 8, -1);
      `CHK("soOe locked", 1'b0, soOe)
      readActive <= 1'b0;
      host_u.sel(1'b1);
      `CHK("standby", 1'b1, standby)
      `CHK("soOe idle", 1'b0, soOe)
      host_u.sel(1'b0);
      `CHK("active", 1'b1, active)
      $display("test locked done");
      for (int k = 0; k < 6; k++) begin
         d = 8'($urandom());
         expQ.push_back(d);
         host_u.xfer(d, 8, (k == 2) ? 4 : -1);
      end
      host_u.xfer(8'hff, 5, -1);
      host_u.sel(1'b1);
      host_u.sel(1'b0);
      d = 8'($urandom());
      expQ.push_back(d);
      host_u.xfer(d, 8, -1);
      tick(3);
      `CHK("bytes left", 0, expQ.size())
      $display("test receive done");
      d = 8'($urandom());
      txReg <= d;
      readActive <= 1'b1;
      tick(3);
      `CHK("soOe read", 1'b1, soOe)
      expQ.push_back(8'h3c);
      host_u.xfer(8'h3c, 8, -1);
      `CHK("so bits", d, host_u.seen)
      host_u.sel(1'b1);
      readActive <= 1'b0;
      `CHK("soOe deselect", 1'b0, soOe)
      nvWriteBusy <= 1'b1;
      tick(3);
      `CHK("standby busy", 1'b0, standby)
      nvWriteBusy <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         wpN <= k[1];
         protectLockEnableBit <= k[0];
         tick(3);
         `CHK("settingsLocked", (k == 1), settingsLocked)
      end
      // a raise needs no trip reset first; write protect stays high through it
      host_u.set_trip();
      `CHK("standby after trip set", 1'b1, standby)
      $display("test read done");
      supplyAboveMin <= 1'b1;
      tick(3);
      `CHK("rstOe low supply", 1'b1, rstOe)
      `CHK("rstOut", 1'b0, rstOut)
      // a dip halfway must restart the delay from zero
      supplyAboveTrip <= 1'b1;
      tick(DLY / 2);
      supplyAboveTrip <= 1'b0;
      tick(2);
      supplyAboveTrip <= 1'b1;
      n = 0;
      while (rstOe === 1'b1 && n < 3 * DLY) begin
         tick(1);
         n++;
      end
      `CHK("release delay", 1'b1, (n >= DLY && n <= DLY + 3))
      supplyAboveTrip <= 1'b0;
      tick(3);
      `CHK("rstOe brownout", 1'b1, rstOe)
      supplyAboveMin <= 1'b0;
      tick(3);
      `CHK("rstOe below min", 1'b0, rstOe)
      $display("test supply done");
      conclude();
   end
endmodule : tb_spi_front_end_reset_supervisor
`default_nettype wire
